// [dv/arp_host_model.sv]
// Host model reading results over the port's pins
`timescale 1ns/100ps
module arp_host_model (
  // Pin wire seen by the host
  input wire logic [15:0] i_bus,
  // Framing pins driven by the host
  output logic o_cs_n,
  output logic o_rd_sclk
);
  // Strobe idles high and stands still between frames
  initial begin
    o_cs_n = 1'b1;
    o_rd_sclk = 1'b1;
  end
  // Samples land between core clock edges; the gap lets the hold reload
  task automatic rd_word(output logic [15:0] w);
    o_cs_n = 1'b0;
    o_rd_sclk = 1'b0;
    #270 w = i_bus;
    o_rd_sclk = 1'b1;
    o_cs_n = 1'b1;
    #430;
  endtask
  // Both strobes of one frame are issued
  task automatic rd_bytes(output logic [7:0] b1, output logic [7:0] b2);
    o_cs_n = 1'b0;
    o_rd_sclk = 1'b0;
    #270 b1 = i_bus[7:0];
    o_rd_sclk = 1'b1;
    #280 o_rd_sclk = 1'b0;
    #270 b2 = i_bus[7:0];
    o_rd_sclk = 1'b1;
    o_cs_n = 1'b1;
    #430;
  endtask
  // 7.5 ns low pulses, spaced so the core can register each bit
  task automatic rd_serial(output logic [15:0] a, output logic [15:0] b);
    o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (i < 15) begin
        #7.5 o_rd_sclk = 1'b0;
        #7.5 o_rd_sclk = 1'b1;
        #285;
      end else begin
        #270;
      end
      a[i] = i_bus[7];
      b[i] = i_bus[8];
    end
    o_cs_n = 1'b1;
    #430;
  endtask
endmodule

// [dv/arp_port_tb.sv]
// Testbench of the result output port
`timescale 1ns/100ps
module arp_port_tb;
  import arp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic res_valid = 1'b0;
  logic [31:0] res_data = 32'h0;
  logic ims = 1'b0;
  logic bsel = 1'b0;
  logic high_byte_first = 1'b0;
  logic ref_sel = 1'b0;
  logic cs_n, sclk, res_ready, int_ref, ok;
  logic [15:0] dout, oe_n, host_drv, wire_bus, w, a, b;
  logic [7:0] b1, b2;
  logic [1:0] mode;
  int err_total = 0;
  int n_checks = 0;
  int cnt;
  // Released lines float high in word mode; otherwise lines 15, 14 carry byte select and byte order, the rest grounded
  assign host_drv = ims ? {bsel, high_byte_first & bsel, 14'h0000} : 16'hFFFF;
  assign wire_bus = (dout & ~oe_n) | (host_drv & oe_n);
  arp_port uut (
    .i_ref_clk(clk), .i_reset(rst), .i_rd_sclk(sclk),
    .i_res_valid(res_valid), .i_res_data(res_data), .o_res_ready(res_ready),
    .i_interface_mode_select(ims), .i_cs_n(cs_n), .i_ref_select(ref_sel),
    .i_parallel_result_bus(wire_bus), .o_parallel_result_bus(dout),
    .o_parallel_result_bus_oe_n(oe_n), .o_int_ref_en(int_ref),
    .o_mode(mode)
  );
  arp_host_model host (.i_bus(wire_bus), .o_cs_n(cs_n), .o_rd_sclk(sclk));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic push(input logic [31:0] d);
    @(negedge clk);
    res_valid = 1'b1;
    res_data = d;
    ok = res_ready;
    @(negedge clk);
    res_valid = 1'b0;
  endtask
  task automatic t_fifo();
    cnt = 0;
    ok = 1'b1;
    while (ok === 1'b1 && cnt < 40) begin
      push({cnt[15:0] ^ 16'h5A00, 16'h0000});
      if (ok === 1'b1) cnt++;
    end
    chk("fill", (cnt >= 32 && cnt <= 33), 32'h1);
    for (int i = 0; i < cnt; i++) begin
      host.rd_word(w);
      chk("word", w, i[15:0] ^ 16'h5A00);
    end
    chk("idle_oe", oe_n, 16'hFFFF);
  endtask
  task automatic t_ref();
    @(negedge clk) ref_sel = 1'b1;
    repeat (5) @(negedge clk);
    chk("ref_on", int_ref, 1'b1);
    ref_sel = 1'b0;
    repeat (5) @(negedge clk);
    chk("ref_off", int_ref, 1'b0);
  endtask
  task automatic t_serial();
    @(negedge clk) ims = 1'b1;
    bsel = 1'b0;
    repeat (3) @(negedge clk);
    chk("mode_ser", mode, 2'h1);
    push({16'hC3A5, 16'h5A3C});
    repeat (3) @(negedge clk);
    host.rd_serial(a, b);
    chk("ser_a", a, 16'hC3A5);
    chk("ser_b", b, 16'h5A3C);
    chk("ser_oe", oe_n, 16'hFFFF);
  endtask
  task automatic t_byte();
    for (int h = 0; h < 2; h++) begin
      @(negedge clk) ims = 1'b1;
      bsel = 1'b1;
      high_byte_first = h[0];
      repeat (3) @(negedge clk);
      chk("mode_byte", mode, 2'h2);
      push({16'hB17E, 16'h0000});
      repeat (3) @(negedge clk);
      host.rd_bytes(b1, b2);
      chk("byte1", b1, h ? 8'hB1 : 8'h7E);
      chk("byte2", b2, h ? 8'h7E : 8'hB1);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("rst_oe", oe_n, 16'hFFFF);
    chk("rst_mode", mode, 2'h0);
    rst = 1'b0;
    t_ref();
    t_fifo();
    t_serial();
    t_byte();
    stop_test();
  end
endmodule

// [rtl/arp_consts.svh]
// Constants of the result output port
`ifndef ARP_CONSTS_SVH
`define ARP_CONSTS_SVH
`define ARP_RESULT_W 16
`define ARP_BYTE_W 8
`define ARP_FIFO_DEPTH 32
`define ARP_SER_A_BIT 7
`define ARP_SER_B_BIT 8
`define ARP_HIGH_BYTE_FIRST_BIT 14
`define ARP_BSEL_BIT 15
`define ARP_BUS_RESET 16'h0000
`endif

// [rtl/arp_fifo.sv]
// Result FIFO with valid/ready on both sides
`timescale 1ns/100ps
module arp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;
  assign o_in_ready = (count_r != (AW+1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data = mem_r[rd_ptr_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [rtl/arp_pkg.sv]
// Types of the result output port
package arp_pkg;
  typedef enum logic [1:0] {
    ARP_MODE_PAR,
    ARP_MODE_SER,
    ARP_MODE_BYTE
  } arp_mode_e;
  // One result pair for the two serial lines / parallel bus
  typedef struct packed {
    logic [15:0] word_a;
    logic [15:0] word_b;
  } arp_pair_s;
  // Pins of the result bus, enable low while driving
  typedef struct packed {
    logic [15:0] data;
    logic [15:0] oe_n;
  } arp_bus_s;
endpackage

// [rtl/arp_port.sv]
// Result output port: parallel word, byte pair or dual serial lines
//
// Contract
// - Word mode drives bus only during read
// - Word mode bits six..zero on lines
// - Mode high, byte select low: serial
// - Both selects high: parallel byte mode
// - Byte mode: result over two reads
// - Line seven is byte MSB
// - High-byte-first input sets byte order
// - Serial: line seven is serial out A
// - Serial: line eight is serial out B
// - Reference select enables internal reference
// - Select fall shows MSB; clock shifts
`timescale 1ns/100ps
`include "arp_consts.svh"
module arp_port
  import arp_pkg::*;
(
  // Core clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Link clock: the read strobe / serial clock pin
  input wire logic i_rd_sclk,
  // Results from the core
  input wire logic i_res_valid,
  input wire logic [31:0] i_res_data,
  output logic o_res_ready,
  // Static and framing pins
  input wire logic i_interface_mode_select,
  input wire logic i_cs_n,
  input wire logic i_ref_select,
  // Bus input side (byte select and byte order share lines 15, 14)
  input wire logic [15:0] i_parallel_result_bus,
  // Bus output side
  output logic [15:0] o_parallel_result_bus,
  output logic [15:0] o_parallel_result_bus_oe_n,
  // Status
  output logic o_int_ref_en,
  output logic [1:0] o_mode
);
  // ****************************************************************
  // Core domain: result buffer and hand-off
  // ****************************************************************
  logic fifo_valid;
  logic [31:0] fifo_data;
  logic take_pulse;
  arp_fifo #(
    .WIDTH(32),
    .DEPTH(`ARP_FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_in_valid(i_res_valid),
    .i_in_data(i_res_data),
    .o_in_ready(o_res_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(take_pulse)
  );

  // Pin and link-side synchronisers into the core domain. Serial bits and
  // byte phase move only on link clock edges while the host waits, so
  // each settles long before the core samples it.
  logic byte_phase_r;
  logic ser_a;
  logic ser_b;
  logic [8:0] pin_s1_r;
  logic [8:0] pin_s2_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pin_s1_r <= 9'h110;
      pin_s2_r <= 9'h110;
    end else begin
      pin_s1_r <= {i_cs_n, i_interface_mode_select,
                   i_parallel_result_bus[`ARP_BSEL_BIT], i_ref_select,
                   i_rd_sclk, i_parallel_result_bus[`ARP_HIGH_BYTE_FIRST_BIT],
                   byte_phase_r, ser_a, ser_b};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic cs_n_s;
  logic mode_sel_s;
  logic byte_sel_s;
  logic ref_sel_s;
  logic rd_n_s;
  logic hi_first_s;
  logic phase_s;
  logic ser_a_s;
  logic ser_b_s;
  assign cs_n_s = pin_s2_r[8];
  assign mode_sel_s = pin_s2_r[7];
  assign byte_sel_s = pin_s2_r[6];
  assign ref_sel_s = pin_s2_r[5];
  assign rd_n_s = pin_s2_r[4];
  assign hi_first_s = pin_s2_r[3];
  assign phase_s = pin_s2_r[2];
  assign ser_a_s = pin_s2_r[1];
  assign ser_b_s = pin_s2_r[0];

  // Mode decode is core-side only; the link reads raw pins, static by host
  arp_mode_e mode_nxt;
  always_comb begin
    if (!mode_sel_s) begin
      mode_nxt = ARP_MODE_PAR;
    end else if (byte_sel_s) begin
      mode_nxt = ARP_MODE_BYTE;
    end else begin
      mode_nxt = ARP_MODE_SER;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_mode <= 2'h0;
      o_int_ref_en <= 1'h0;
    end else begin
      o_mode <= mode_nxt;
      o_int_ref_en <= ref_sel_s;
    end
  end

  // Holding word offered to the link; reloaded while chip select is high
  logic [31:0] hold_r;
  logic hold_full_r;
  logic cs_n_d_r;
  assign take_pulse = fifo_valid && cs_n_s && !hold_full_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cs_n_d_r <= 1'b1;
    end else begin
      cs_n_d_r <= cs_n_s;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      hold_r <= 32'h0000_0000;
      hold_full_r <= 1'b0;
    end else if (take_pulse) begin
      hold_r <= fifo_data;
      hold_full_r <= 1'b1;
    end else if (cs_n_s && !cs_n_d_r) begin
      // Frame finished: the word is consumed
      hold_full_r <= 1'b0;
    end
  end
  // hold_r only changes while cs_n is high, so link logic may sample it
  // inside a frame without a handshake; the trade is one frame per word.

  // ****************************************************************
  // Link domain: serial shifter and byte phase
  // ****************************************************************
  // Async-load of pin data is avoided: the frame's own chip select clears
  // the shifter count asynchronously while high, so it is zero at the fall.
  logic [4:0] bit_cnt_r;
  always_ff @(posedge i_rd_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_cnt_r <= 5'h00;
      byte_phase_r <= 1'b0;
    end else begin
      bit_cnt_r <= (bit_cnt_r == 5'h10) ? bit_cnt_r : bit_cnt_r + 5'h01;
      byte_phase_r <= ~byte_phase_r;
    end
  end
  // Shift index: MSB shown at the fall, next bit each rising clock
  logic [3:0] sh_idx;
  assign sh_idx = 4'(15 - bit_cnt_r[3:0]);
  logic [15:0] word;
  logic [15:0] word_b;
  assign word = hold_r[31:16];
  assign word_b = hold_r[15:0];
  // Past the sixteenth bit the lines read zero
  assign ser_a = (bit_cnt_r[4]) ? 1'b0 : word[sh_idx];
  assign ser_b = (bit_cnt_r[4]) ? 1'b0 : word_b[sh_idx];

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  logic [7:0] byte_sel;
  always_comb begin
    // Second read of the pair flips the order
    if (hi_first_s ^ phase_s) begin
      byte_sel = word[15:8];
    end else begin
      byte_sel = word[7:0];
    end
  end

  // Pins answer three core cycles after the strobes, a limit on host speed
  arp_bus_s bus_nxt;
  always_comb begin
    bus_nxt.data = `ARP_BUS_RESET;
    bus_nxt.oe_n = 16'hFFFF;
    if (!mode_sel_s) begin
      if (!cs_n_s && !rd_n_s) begin
        bus_nxt.data = word;
        bus_nxt.oe_n = 16'h0000;
      end
    end else if (byte_sel_s) begin
      if (!cs_n_s && !rd_n_s) begin
        bus_nxt.data[7:0] = byte_sel;
        bus_nxt.oe_n[7:0] = 8'h00;
      end
    end else if (!cs_n_s) begin
      bus_nxt.data[`ARP_SER_A_BIT] = ser_a_s;
      bus_nxt.data[`ARP_SER_B_BIT] = ser_b_s;
      bus_nxt.oe_n[`ARP_SER_A_BIT] = 1'b0;
      bus_nxt.oe_n[`ARP_SER_B_BIT] = 1'b0;
    end
  end
  // The pins must follow strobes combinationally on a real part; here
  // they are registered on the fast core clock for a clean output.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_parallel_result_bus <= `ARP_BUS_RESET;
      o_parallel_result_bus_oe_n <= 16'hFFFF;
    end else begin
      o_parallel_result_bus <= bus_nxt.data;
      o_parallel_result_bus_oe_n <= bus_nxt.oe_n;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_word_idle_hiz:
    assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $past(!mode_sel_s && cs_n_s) |->
      o_parallel_result_bus_oe_n == 16'hFFFF)
    else $error("bus driven outside read");
  a_word_low_bits:
    assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $past(!mode_sel_s && !cs_n_s && !rd_n_s) |->
      o_parallel_result_bus[6:0] == $past(word[6:0]))
    else $error("low bits wrong");
  a_ser_mode_dec:
    assert property (@(posedge i_ref_clk) disable iff (i_reset)
    mode_sel_s && !byte_sel_s |=> o_mode == 2'(ARP_MODE_SER))
    else $error("serial mode not decoded");
  a_byte_mode_dec:
    assert property (@(posedge i_ref_clk) disable iff (i_reset)
    mode_sel_s && byte_sel_s |=> o_mode == 2'(ARP_MODE_BYTE))
    else $error("byte mode not decoded");
  a_byte_upper_hiz:
    assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $past(mode_sel_s) |->
      o_parallel_result_bus_oe_n[15:9] == 7'h7F)
    else $error("upper lines driven in byte/serial");
  a_byte_order:
    assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $past(mode_sel_s && byte_sel_s && !cs_n_s && !rd_n_s && !phase_s
      && hi_first_s) |->
      o_parallel_result_bus[7:0] == $past(word[15:8]))
    else $error("byte order wrong");
  a_ser_a_line:
    assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $past(mode_sel_s && !byte_sel_s && !cs_n_s)
      |-> !o_parallel_result_bus_oe_n[7] && !o_parallel_result_bus_oe_n[8])
    else $error("serial lines not driven");
  a_ref_follow:
    assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $rose(ref_sel_s) |=> o_int_ref_en)
    else $error("reference enable lags");
endmodule
